// [verilog/phc_map.svh]
`ifndef PHC_MAP_SVH
`define PHC_MAP_SVH
// CSR addresses of the three registers
`define PHC_ADDR_PAUSE 12'h7c2
`define PHC_ADDR_THRESH 12'h7ce
`define PHC_ADDR_STATUS 12'h7cf
// Threshold register fields
`define PHC_THR_EN_BIT 0
`define PHC_THR_EXP_LSB 1
`define PHC_THR_EXP_MSB 5
// Status register fields
`define PHC_STS_FETCH_BIT 0
`define PHC_STS_LDST_BIT 1
// Reset values
`define PHC_PAUSE_RST 32'h0000_0000
`define PHC_THR_RST 6'h00
`define PHC_STS_RST 2'h0
`endif

// [verilog/phc_pkg.sv]
package phc_pkg;
  // Halt sequencing seen by the forced-halt logic
  typedef enum logic [1:0] {
    PHC_RUN,
    PHC_WAIT,
    PHC_FORCE,
    PHC_HALTED
  } phc_halt_state_t;
endpackage

// [verilog/phc_pause_and_forced_halt_ctrl.sv]
// Operation
// - Pause count is 32 bits, writes take any value, reads return zero.
// - A nonzero pause write stalls execution but the activity state stays Running.
// - The remaining pause count drops by one every core clock.
// - Execution resumes when the count reaches zero or on any interrupt.
// - Stall length may differ from the count by a few cycles of skid.
// - A power halt during a pause freezes the countdown until the power halt ends.
// - Wait-for-interrupt executes as a no-operation without stalling.
// - Threshold bit 0 enables the forced halt timeout, reset disabled.
// - Enabled timeout counter increments each clock while halt waits on bus.
// - If the bus drains before timeout, debug halt is entered normally.
// - At count at or above two to the exponent, abort bus and halt.
// - Threshold bits 5 to 1 hold the 5-bit exponent, up to 2**31.
// - Timeout counter clears at reset and whenever debug halt is left.
// - Entering debug halt captures whether any bus transactions were aborted.
// - Status bit 1 set means load/store transactions were aborted.
// - Status bit 0 set means fetch transactions were aborted.
// - The debugger may clear status bits; clearing is never required.
// - Reserved bits read zero; writable fields return legal values.
`timescale 1ns/100ps
`default_nettype none
`include "phc_map.svh"
module phc_pause_and_forced_halt_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic csr_wr_en,
  input wire logic csr_rd_en,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata,
  output logic csr_hit,
  input wire logic wfi_issue,
  input wire logic irq_any,
  input wire logic power_halted_state,
  input wire logic debug_halt_req,
  input wire logic debug_resume,
  input wire logic load_store_unit_pending,
  input wire logic fetch_pending,
  input wire logic core_quiesced,
  output logic pause_stall,
  output logic wfi_stall,
  output logic activity_running,
  output logic load_store_unit_abort,
  output logic fetch_abort,
  output logic debug_halted_state
);

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] r);
    addr_is = (a == r);
  endfunction

  wire logic sel_pause = addr_is(csr_addr, `PHC_ADDR_PAUSE);
  wire logic sel_thr = addr_is(csr_addr, `PHC_ADDR_THRESH);
  wire logic sel_sts = addr_is(csr_addr, `PHC_ADDR_STATUS);
  wire logic wr_pause = csr_wr_en && sel_pause;
  wire logic wr_thr = csr_wr_en && sel_thr;
  wire logic wr_sts = csr_wr_en && sel_sts;

  logic [31:0] pause_left;
  logic pause_active;
  logic thr_en;
  logic [4:0] thr_exp;
  logic sts_load_store;
  logic sts_fetch;
  logic [31:0] tmo_cnt;
  phc_pkg::phc_halt_state_t hstate;
  phc_pkg::phc_halt_state_t next_hstate;

  // ------------------------------------------------------------
  // Pause counter
  // ------------------------------------------------------------
  // Countdown holds while the power manager has the core halted
  wire logic pause_tick = pause_active && !power_halted_state;
  wire logic pause_done = pause_tick && (pause_left <= 32'h0000_0001 || irq_any);
  // Zero write gives no stall, so an idle write costs nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_left <= `PHC_PAUSE_RST;
      pause_active <= 1'b0;
    end else if (wr_pause) begin
      pause_left <= csr_wdata;
      pause_active <= (csr_wdata != 32'h0000_0000);
    end else if (pause_done) begin
      pause_left <= 32'h0000_0000;
      pause_active <= 1'b0;
    end else if (pause_tick) begin
      pause_left <= pause_left - 32'h0000_0001;
    end
  end

  // Stall is held while halted too; the halt itself owns the core then
  assign pause_stall = pause_active;
  assign activity_running = !power_halted_state && !debug_halted_state;
  // Wait-for-interrupt never stalls: treated as a plain no-op
  assign wfi_stall = 1'b0 & wfi_issue;

  // ------------------------------------------------------------
  // Forced debug halt
  // ------------------------------------------------------------
  wire logic bus_busy = load_store_unit_pending || fetch_pending;
  wire logic [31:0] thr_val = 32'h0000_0001 << thr_exp;
  wire logic tmo_hit = thr_en && (tmo_cnt >= thr_val);

  // Halt sequencing
  always_comb begin
    next_hstate = hstate;
    case (hstate)
      phc_pkg::PHC_RUN: begin
        if (debug_halt_req) begin
          next_hstate = phc_pkg::PHC_WAIT;
        end
      end
      phc_pkg::PHC_WAIT: begin
        if (!bus_busy && core_quiesced) begin
          next_hstate = phc_pkg::PHC_HALTED;
        end else if (tmo_hit) begin
          next_hstate = phc_pkg::PHC_FORCE;
        end
      end
      phc_pkg::PHC_FORCE: begin
        next_hstate = phc_pkg::PHC_HALTED;
      end
      phc_pkg::PHC_HALTED: begin
        if (debug_resume) begin
          next_hstate = phc_pkg::PHC_RUN;
        end
      end
      default: begin
        next_hstate = phc_pkg::PHC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hstate <= phc_pkg::PHC_RUN;
    end else begin
      hstate <= next_hstate;
    end
  end

  // Timeout counter; saturates so it cannot wrap below the threshold
  // Once started it keeps counting until halt, even if the bus drains first
  wire logic tmo_run = thr_en && (hstate == phc_pkg::PHC_WAIT)
    && (bus_busy || tmo_cnt != 32'h0000_0000);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmo_cnt <= 32'h0000_0000;
    end else if (hstate == phc_pkg::PHC_HALTED && debug_resume) begin
      tmo_cnt <= 32'h0000_0000;
    end else if (tmo_run && tmo_cnt != 32'hffff_ffff) begin
      tmo_cnt <= tmo_cnt + 32'h0000_0001;
    end
  end

  // Aborts pulse for one cycle, only for units that still have traffic
  wire logic force_now = (hstate == phc_pkg::PHC_FORCE);
  wire logic load_store_cut = force_now && load_store_unit_pending;
  wire logic fetch_cut = force_now && fetch_pending;
  assign load_store_unit_abort = load_store_cut;
  assign fetch_abort = fetch_cut;
  assign debug_halted_state = (hstate == phc_pkg::PHC_HALTED);
  wire logic halt_entry = (next_hstate == phc_pkg::PHC_HALTED) && !debug_halted_state;

  // ------------------------------------------------------------
  // Threshold and status registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {thr_exp, thr_en} <= `PHC_THR_RST;
    end else if (wr_thr) begin
      thr_en <= csr_wdata[`PHC_THR_EN_BIT];
      thr_exp <= csr_wdata[`PHC_THR_EXP_MSB:`PHC_THR_EXP_LSB];
    end
  end

  // Entry capture wins over a debugger write in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {sts_load_store, sts_fetch} <= `PHC_STS_RST;
    end else if (halt_entry) begin
      sts_load_store <= load_store_cut;
      sts_fetch <= fetch_cut;
    end else if (wr_sts) begin
      sts_load_store <= csr_wdata[`PHC_STS_LDST_BIT];
      sts_fetch <= csr_wdata[`PHC_STS_FETCH_BIT];
    end
  end

  // Read mux; pause reads zero, reserved bits zero
  wire logic [31:0] rd_thr = {26'h0000000, thr_exp, thr_en};
  wire logic [31:0] rd_sts = {30'h00000000, sts_load_store, sts_fetch};
  wire logic [31:0] rd_mux = sel_thr ? rd_thr : (sel_sts ? rd_sts : 32'h0000_0000);
  assign csr_hit = sel_pause || sel_thr || sel_sts;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csr_rdata <= 32'h0000_0000;
    end else if (csr_rd_en) begin
      csr_rdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_pause_read_zero;
    csr_rd_en && sel_pause |=> csr_rdata == 32'h0000_0000;
  endproperty
  a_pause_read_zero: assert property (p_pause_read_zero) else $error("pause read not zero");

  property p_pause_dec;
    pause_tick && !pause_done && !wr_pause |=> pause_left == $past(pause_left) - 32'h0000_0001;
  endproperty
  a_pause_dec: assert property (p_pause_dec) else $error("pause did not decrement");

  property p_irq_end;
    pause_tick && irq_any && !wr_pause |=> !pause_active && pause_left == 32'h0000_0000;
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("interrupt did not end pause");

  property p_freeze;
    pause_active && power_halted_state && !wr_pause |=> $stable(pause_left);
  endproperty
  a_freeze: assert property (p_freeze) else $error("pause ran while halted");

  property p_no_wfi;
    wfi_issue |-> !wfi_stall;
  endproperty
  a_no_wfi: assert property (p_no_wfi) else $error("wait-for-interrupt stalled");

  property p_no_abort_off;
    !thr_en |-> !load_store_unit_abort && !fetch_abort;
  endproperty
  a_no_abort_off: assert property (p_no_abort_off) else $error("abort with timeout off");

  property p_cnt_hold_off;
    !thr_en && !(debug_halted_state && debug_resume) |=> $stable(tmo_cnt);
  endproperty
  a_cnt_hold_off: assert property (p_cnt_hold_off) else $error("counted while off");

  sequence s_timeout;
    hstate == phc_pkg::PHC_WAIT && tmo_hit && bus_busy;
  endsequence
  property p_force;
    s_timeout ##0 bus_busy |=> force_now ##1 debug_halted_state;
  endproperty
  a_force: assert property (p_force) else $error("forced halt not taken");

  property p_clear_exit;
    debug_halted_state && debug_resume |=> tmo_cnt == 32'h0000_0000;
  endproperty
  a_clear_exit: assert property (p_clear_exit) else $error("timeout not cleared");

  // Halt entry: status capture and normal quiescence
  property p_capture;
    force_now && load_store_unit_pending |=> sts_load_store && debug_halted_state;
  endproperty
  a_capture: assert property (p_capture) else $error("status not captured");

  property p_fetch_cap;
    force_now && fetch_pending |=> sts_fetch && debug_halted_state;
  endproperty
  a_fetch_cap: assert property (p_fetch_cap) else $error("fetch status lost");

  property p_quiet_entry;
    hstate == phc_pkg::PHC_WAIT && !bus_busy && core_quiesced
      |=> debug_halted_state && !sts_load_store && !sts_fetch;
  endproperty
  a_quiet_entry: assert property (p_quiet_entry) else $error("normal halt wrong");

  property p_no_early;
    hstate == phc_pkg::PHC_WAIT && !tmo_hit |=> !force_now;
  endproperty
  a_no_early: assert property (p_no_early) else $error("forced before timeout");

  property p_stall_start;
    wr_pause && csr_wdata != 32'h0000_0000 |=> pause_stall;
  endproperty
  a_stall_start: assert property (p_stall_start) else $error("pause did not stall");

  property p_count_end;
    pause_tick && pause_left == 32'h0000_0001 && !wr_pause |=> !pause_stall;
  endproperty
  a_count_end: assert property (p_count_end) else $error("pause overran count");

  // Register reads and writes
  property p_thr_read;
    csr_rd_en && sel_thr |=> csr_rdata[31:6] == 26'h0;
  endproperty
  a_thr_read: assert property (p_thr_read) else $error("threshold reserved bits set");

  property p_sts_read;
    csr_rd_en && sel_sts |=> csr_rdata[31:2] == 30'h0;
  endproperty
  a_sts_read: assert property (p_sts_read) else $error("status reserved bits set");

  property p_wr_thr;
    wr_thr |=> thr_en == $past(csr_wdata[`PHC_THR_EN_BIT])
      && thr_exp == $past(csr_wdata[`PHC_THR_EXP_MSB:`PHC_THR_EXP_LSB]);
  endproperty
  a_wr_thr: assert property (p_wr_thr) else $error("threshold write lost");

  property p_sts_write;
    wr_sts && !halt_entry |=> sts_load_store == $past(csr_wdata[`PHC_STS_LDST_BIT])
      && sts_fetch == $past(csr_wdata[`PHC_STS_FETCH_BIT]);
  endproperty
  a_sts_write: assert property (p_sts_write) else $error("status write lost");

endmodule
`default_nettype wire

// [dv/phc_bus_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Bus units behind the core: load/store and fetch
// ----------------------------------------
module phc_bus_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start_ls,
  input wire logic start_fetch,
  input wire logic [7:0] latency,
  input wire logic load_store_unit_abort,
  input wire logic fetch_abort,
  output logic load_store_unit_pending,
  output logic fetch_pending
);
  logic [7:0] ls_left;
  logic [7:0] f_left;
  // Latency 8'hff keeps a transfer open until the core gives up on it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ls_left <= 8'h00;
      f_left <= 8'h00;
    end else begin
      if (start_ls) ls_left <= latency;
      else if (load_store_unit_abort) ls_left <= 8'h00;
      else if (ls_left != 8'h00 && ls_left != 8'hff) ls_left <= ls_left - 8'h01;
      if (start_fetch) f_left <= latency;
      else if (fetch_abort) f_left <= 8'h00;
      else if (f_left != 8'h00 && f_left != 8'hff) f_left <= f_left - 8'h01;
    end
  end
  // Pending while any count remains, so a drained unit reads idle
  assign load_store_unit_pending = (ls_left != 8'h00);
  assign fetch_pending = (f_left != 8'h00);
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "phc_map.svh"
module tb;
  logic clk, rst_b, wr, rd, wfi, irq, pwr, hreq, hres, quiet, s_ls, s_f;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] lat;
  logic hit, stall, wstall, run, ls_ab, f_ab, halted, ls_p, f_p;
  logic [1:0] ab;
  int miscompares, num_checks, n;
  phc_pause_and_forced_halt_ctrl phc_pause_and_forced_halt_ctrl_i (.clk(clk), .rst_b(rst_b),
    .csr_wr_en(wr), .csr_rd_en(rd), .csr_addr(addr), .csr_wdata(wdata), .csr_rdata(rdata),
    .csr_hit(hit), .wfi_issue(wfi), .irq_any(irq), .power_halted_state(pwr),
    .debug_halt_req(hreq), .debug_resume(hres), .load_store_unit_pending(ls_p),
    .fetch_pending(f_p), .core_quiesced(quiet), .pause_stall(stall), .wfi_stall(wstall),
    .activity_running(run), .load_store_unit_abort(ls_ab), .fetch_abort(f_ab),
    .debug_halted_state(halted));
  phc_bus_model phc_bus_model_i (.clk(clk), .rst_b(rst_b), .start_ls(s_ls),
    .start_fetch(s_f), .latency(lat), .load_store_unit_abort(ls_ab), .fetch_abort(f_ab),
    .load_store_unit_pending(ls_p), .fetch_pending(f_p));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task csr_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task csr_read(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  // Bounded wait: sel 0 for pause end, sel 1 for debug halt entry; aborts are collected
  task wait_for(input bit sel, output int cnt);
    cnt = 0;
    while (sel ? halted !== 1'b1 : stall !== 1'b0) begin
      @(posedge clk);
      #1 ab = ab | {ls_ab, f_ab};
      cnt++;
      if (cnt > 200) begin miscompares++; end_sim; end
    end
  endtask
  // Opens bus transfers together with a halt request, then waits for the halt
  task do_halt(input logic ls, input logic f, input logic [7:0] l, output int cnt);
    ab = 2'b00;
    @(posedge clk) begin s_ls <= ls; s_f <= f; lat <= l; hreq <= 1'b1; end
    @(posedge clk) begin s_ls <= 1'b0; s_f <= 1'b0; end
    wait_for(1'b1, cnt);
    @(posedge clk) hreq <= 1'b0;
  endtask
  task resume;
    @(posedge clk) hres <= 1'b1;
    @(posedge clk) hres <= 1'b0;
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst_b, wr, rd, wfi, irq, pwr, hreq, hres, s_ls, s_f} = '0;
    quiet = 1'b1; addr = 12'h000; wdata = 32'h0; lat = 8'h00; ab = 2'b00;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    csr_read(`PHC_ADDR_THRESH, 32'h0);
    csr_read(`PHC_ADDR_STATUS, 32'h0);
    csr_read(12'h7c3, 32'h0);
    #1 check(hit, 1'b0);
    csr_write(`PHC_ADDR_THRESH, 32'hffff_ffff);
    csr_read(`PHC_ADDR_THRESH, 32'h0000_003f);
    // Short pause with WFI asserted alongside
    wfi <= 1'b1;
    csr_write(`PHC_ADDR_PAUSE, 32'h3);
    @(posedge clk) #1 check(stall, 1'b1);
    check(run, 1'b1);
    check(wstall, 1'b0);
    wait_for(1'b0, n);
    check(n >= 1 && n <= 5, 1'b1);
    @(posedge clk) wfi <= 1'b0;
    csr_read(`PHC_ADDR_PAUSE, 32'h0);
    // Interrupt cuts a long pause short and drops the remainder
    csr_write(`PHC_ADDR_PAUSE, 32'h64);
    repeat (5) @(posedge clk);
    irq <= 1'b1;
    wait_for(1'b0, n);
    check(n <= 3, 1'b1);
    @(posedge clk) irq <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check(stall, 1'b0);
    // Power halt freezes the countdown
    csr_write(`PHC_ADDR_PAUSE, 32'ha);
    pwr <= 1'b1;
    repeat (20) @(posedge clk);
    #1 check(stall, 1'b1);
    check(run, 1'b0);
    @(posedge clk) pwr <= 1'b0;
    wait_for(1'b0, n);
    check(n >= 3 && n <= 12, 1'b1);
    // Forced halt with threshold 16, both units stuck
    csr_write(`PHC_ADDR_THRESH, 32'h9);
    do_halt(1'b1, 1'b1, 8'hff, n);
    check(n >= 16 && n <= 24, 1'b1);
    check(ab, 2'b11);
    csr_read(`PHC_ADDR_STATUS, 32'h3);
    resume;
    csr_write(`PHC_ADDR_STATUS, 32'h0);
    csr_read(`PHC_ADDR_STATUS, 32'h0);
    // Fetch drains before the threshold; a stale counter would force it
    do_halt(1'b0, 1'b1, 8'h0c, n);
    check(ab, 2'b00);
    csr_read(`PHC_ADDR_STATUS, 32'h0);
    resume;
    // Timeout off: halt waits for a busy core, then for the slow load/store unit
    csr_write(`PHC_ADDR_THRESH, 32'h0);
    @(posedge clk) begin quiet <= 1'b0; hreq <= 1'b1; end
    repeat (10) @(posedge clk);
    #1 check(halted, 1'b0);
    @(posedge clk) begin quiet <= 1'b1; hreq <= 1'b0; end
    wait_for(1'b1, n);
    resume;
    do_halt(1'b1, 1'b0, 8'h28, n);
    check(n >= 38, 1'b1);
    check(ab, 2'b00);
    resume;
    end_sim;
  end
endmodule
`default_nettype wire
